/* csl_console_uart_defs.vh */
// constants shared by the console serial line block
// assumes a 40 MHz system clock and byte addresses on the processor port
`ifndef CSL_CONSOLE_UART_DEFS_VH
`define CSL_CONSOLE_UART_DEFS_VH

// ****************************************
// register byte addresses
// ****************************************
`define CSL_ADDR_RX_CTRL_STATUS 32'h10140080
`define CSL_ADDR_RX_BUFFER 32'h10140084
`define CSL_ADDR_TX_CTRL_STATUS 32'h10140088
`define CSL_ADDR_TX_BUFFER 32'h1014008c
`define CSL_ADDR_BOOT_DIAG 32'h10084004

// ****************************************
// field positions
// ****************************************
`define CSL_BIT_DONE 7
`define CSL_BIT_IE 6
`define CSL_BIT_ANY_ERR 15
`define CSL_BIT_OVERRUN 14
`define CSL_BIT_FRAMING 13
`define CSL_BIT_BREAK 11
`define CSL_BIT_LOOPBACK 2
`define CSL_BIT_FORCE_SPACE 0
`define CSL_BIT_RATE_LO 4

// ****************************************
// reset values
// ****************************************
`define CSL_RESET_TX_CAN_ACCEPT 1'b1
`define CSL_RESET_FLAG 1'b0

// ****************************************
// interrupt identity
// ****************************************
`define CSL_IRQ_LEVEL 5'h0e
`define CSL_VECTOR_RX 8'hf8
`define CSL_VECTOR_TX 8'hfc

// ****************************************
// timing
// ****************************************
`define CSL_CLK_HZ 40000000
`define CSL_BAUD_BASE 300
`define CSL_OVERSAMPLE 16
`define CSL_BREAK_BITS 20
`define CSL_DATA_BITS 8

`endif

/* csl_console_uart.v */
// console serial line: 8 data bits, no parity, one stop bit, full duplex
// assumes all inputs synchronous to clock; processor port is single-cycle
`timescale 1ns/1ps
`include "csl_console_uart_defs.vh"
`default_nettype none

module csl_console_uart (
    input wire clock,
    input wire rst_n,
    input wire [31:0] addr,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] wr_data,
    output reg [31:0] rd_data,
    input wire [2:0] baud_select,
    input wire [2:0] rate_switch_in,
    input wire dc_power_ok,
    input wire system_ctrl_hold,
    input wire serial_in,
    output wire serial_out,
    output wire rx_irq_req,
    output wire tx_irq_req,
    output wire [4:0] irq_level,
    output wire [7:0] irq_vector
);

    localparam RX_IDLE = 4'b0001;
    localparam RX_START = 4'b0010;
    localparam RX_DATA = 4'b0100;
    localparam RX_STOP = 4'b1000;
    // full-width products first, then cut to the counter widths on purpose
    localparam [31:0] DIV_FULL = `CSL_CLK_HZ / (`CSL_OVERSAMPLE * `CSL_BAUD_BASE);
    localparam [31:0] BREAK_FULL = `CSL_BREAK_BITS * `CSL_OVERSAMPLE;
    localparam [13:0] DIV_BASE = DIV_FULL[13:0];
    localparam [8:0] BREAK_TICKS = BREAK_FULL[8:0];

    reg rx_char_done;
    reg rx_irq_enable;
    reg overrun_flag;
    reg framing_flag;
    reg break_seen;
    reg [7:0] rx_data;
    reg tx_can_accept;
    reg tx_irq_enable;
    reg loopback_test;
    reg force_space;
    reg [7:0] tx_hold;
    reg [13:0] tick_cnt;
    reg [3:0] rx_state;
    reg [3:0] rx_phase;
    reg [2:0] rx_bit;
    reg [7:0] rx_shift;
    reg rx_prev;
    reg [8:0] space_run;
    reg break_armed;
    reg tx_busy;
    reg [3:0] tx_phase;
    reg [3:0] tx_bit;
    reg [9:0] tx_shift;
    reg tx_line;
    reg space_line;
    wire soft_init;
    wire [13:0] divisor;
    wire tick;
    wire rx_line;
    wire sel_receive_control_status;
    wire sel_receive_data_buffer;
    wire sel_transmit_control_status;
    wire sel_transmit_data_buffer;
    wire rx_complete;
    wire rx_stop_ok;
    wire read_receive_data_buffer;
    wire break_hit;

    // ****************************************
    // shared baud generator and decode
    // ****************************************
    // one oversample tick per divisor count; both directions share it
    assign divisor = DIV_BASE >> baud_select;
    assign tick = (tick_cnt == 14'h0000);
    assign soft_init = ~dc_power_ok & ~system_ctrl_hold;
    assign sel_receive_control_status = (addr == `CSL_ADDR_RX_CTRL_STATUS);
    assign sel_receive_data_buffer = (addr == `CSL_ADDR_RX_BUFFER);
    assign sel_transmit_control_status = (addr == `CSL_ADDR_TX_CTRL_STATUS);
    assign sel_transmit_data_buffer = (addr == `CSL_ADDR_TX_BUFFER);
    assign read_receive_data_buffer = rd_en & sel_receive_data_buffer;

    // baud counter reloads so a rate change takes effect within one tick
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt <= 14'h0000;
        else if (tick)
            tick_cnt <= divisor - 14'h0001;
        else
            tick_cnt <= tick_cnt - 14'h0001;
    end

    // ****************************************
    // receiver
    // ****************************************
    // loopback takes the internal transmit line instead of the pin
    assign rx_line = loopback_test ? tx_line : serial_in;
    assign rx_stop_ok = rx_line;
    assign rx_complete = tick & (rx_state == RX_STOP) & (rx_phase == 4'h7);
    assign break_hit = tick & break_armed & ~rx_line & (space_run == BREAK_TICKS - 9'h001);

    // start edge, then sample each bit at phase 7 of 16 (mid-bit)
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state <= RX_IDLE;
            rx_phase <= 4'h0;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
            rx_prev <= 1'b1;
        end
        else if (soft_init)
        begin
            rx_state <= RX_IDLE;
            rx_phase <= 4'h0;
            rx_bit <= 3'h0;
            rx_prev <= 1'b1;
        end
        else if (tick)
        begin
            rx_prev <= rx_line;
            rx_phase <= rx_phase + 4'h1;
            case (rx_state)
                RX_IDLE:
                begin
                    rx_phase <= 4'h0;
                    if (rx_prev & ~rx_line)
                        rx_state <= RX_START;
                end
                RX_START:
                begin
                    if (rx_phase == 4'h7)
                    begin
                        // a glitch shorter than half a bit is not a start
                        rx_state <= rx_line ? RX_IDLE : RX_START;
                    end
                    if (rx_phase == 4'hf)
                    begin
                        rx_state <= RX_DATA;
                        rx_bit <= 3'h0;
                    end
                end
                RX_DATA:
                begin
                    if (rx_phase == 4'h7)
                        rx_shift <= {rx_line, rx_shift[7:1]};
                    if (rx_phase == 4'hf)
                    begin
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7)
                            rx_state <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    // idle waits for a fresh mark-to-space edge afterwards
                    if (rx_phase == 4'h7)
                        rx_state <= RX_IDLE;
                end
                default:
                    rx_state <= RX_IDLE;
            endcase
        end
    end

    // space run length in oversample ticks; mark rearms break detection
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            space_run <= 9'h000;
            break_armed <= 1'b1;
        end
        else if (soft_init)
        begin
            space_run <= 9'h000;
            break_armed <= 1'b1;
        end
        else if (tick)
        begin
            if (rx_line)
            begin
                space_run <= 9'h000;
                break_armed <= 1'b1;
            end
            else if (break_hit)
            begin
                space_run <= 9'h000;
                break_armed <= 1'b0;
            end
            else if (space_run != BREAK_TICKS)
                space_run <= space_run + 9'h001;
        end
    end

    // receive status; a set in the same cycle as a read wins
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_char_done <= `CSL_RESET_FLAG;
            overrun_flag <= `CSL_RESET_FLAG;
            framing_flag <= `CSL_RESET_FLAG;
            break_seen <= `CSL_RESET_FLAG;
            rx_data <= 8'h00;
        end
        else if (soft_init)
        begin
            rx_char_done <= `CSL_RESET_FLAG;
            overrun_flag <= `CSL_RESET_FLAG;
            framing_flag <= `CSL_RESET_FLAG;
            break_seen <= `CSL_RESET_FLAG;
            rx_data <= 8'h00;
        end
        else
        begin
            if (rx_complete)
            begin
                rx_data <= rx_shift;
                rx_char_done <= 1'b1;
                overrun_flag <= rx_char_done & ~read_receive_data_buffer;
                framing_flag <= ~rx_stop_ok;
            end
            else if (read_receive_data_buffer)
                rx_char_done <= 1'b0;
            if (break_hit)
            begin
                break_seen <= 1'b1;
                framing_flag <= 1'b1;
            end
            else if (read_receive_data_buffer)
                break_seen <= 1'b0;
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    // holding register plus 10-bit shifter: start, 8 data, stop
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_can_accept <= `CSL_RESET_TX_CAN_ACCEPT;
            tx_hold <= 8'h00;
            tx_busy <= 1'b0;
            tx_phase <= 4'h0;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3ff;
            tx_line <= 1'b1;
            space_line <= 1'b0;
        end
        else if (soft_init)
        begin
            tx_can_accept <= `CSL_RESET_TX_CAN_ACCEPT;
            tx_busy <= 1'b0;
            tx_phase <= 4'h0;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3ff;
            tx_line <= 1'b1;
            space_line <= 1'b0;
        end
        else
        begin
            // a write while full is dropped rather than corrupting the hold
            if (wr_en & sel_transmit_data_buffer & tx_can_accept)
            begin
                tx_hold <= wr_data[7:0];
                tx_can_accept <= 1'b0;
            end
            else if (~tx_can_accept & ~tx_busy)
            begin
                tx_shift <= {1'b1, tx_hold, 1'b0};
                tx_busy <= 1'b1;
                tx_can_accept <= 1'b1;
                tx_phase <= 4'h0;
                tx_bit <= 4'h0;
            end
            if (tx_busy & tick)
            begin
                tx_phase <= tx_phase + 4'h1;
                if (tx_phase == 4'h0)
                    tx_line <= tx_shift[0];
                if (tx_phase == 4'hf)
                begin
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_bit <= tx_bit + 4'h1;
                    if (tx_bit == 4'h9)
                        tx_busy <= 1'b0;
                end
            end
            else if (~tx_busy)
                tx_line <= 1'b1;
            // space starts only between characters, then holds while set
            space_line <= force_space & (space_line | ~tx_busy);
        end
    end

    // loopback keeps the pin at mark; otherwise break forces the pin to space
    assign serial_out = loopback_test | (tx_line & ~space_line);

    // ****************************************
    // processor register port
    // ****************************************
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_irq_enable <= `CSL_RESET_FLAG;
            tx_irq_enable <= `CSL_RESET_FLAG;
            loopback_test <= `CSL_RESET_FLAG;
            force_space <= `CSL_RESET_FLAG;
        end
        else if (soft_init)
        begin
            rx_irq_enable <= `CSL_RESET_FLAG;
            tx_irq_enable <= `CSL_RESET_FLAG;
            loopback_test <= `CSL_RESET_FLAG;
            force_space <= `CSL_RESET_FLAG;
        end
        else if (wr_en)
        begin
            // only the writable bits are taken; others are ignored
            if (sel_receive_control_status)
                rx_irq_enable <= wr_data[`CSL_BIT_IE];
            if (sel_transmit_control_status)
            begin
                tx_irq_enable <= wr_data[`CSL_BIT_IE];
                loopback_test <= wr_data[`CSL_BIT_LOOPBACK];
                force_space <= wr_data[`CSL_BIT_FORCE_SPACE];
            end
        end
    end

    // registered read data; unmapped and write-only addresses read zero
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= 32'h00000000;
        else
        begin
            rd_data <= 32'h00000000;
            if (rd_en & sel_receive_control_status)
            begin
                rd_data[`CSL_BIT_DONE] <= rx_char_done;
                rd_data[`CSL_BIT_IE] <= rx_irq_enable;
            end
            if (read_receive_data_buffer)
            begin
                rd_data[7:0] <= rx_data;
                rd_data[`CSL_BIT_ANY_ERR] <= overrun_flag | framing_flag;
                rd_data[`CSL_BIT_OVERRUN] <= overrun_flag;
                rd_data[`CSL_BIT_FRAMING] <= framing_flag;
                rd_data[`CSL_BIT_BREAK] <= break_seen;
            end
            if (rd_en & sel_transmit_control_status)
            begin
                rd_data[`CSL_BIT_DONE] <= tx_can_accept;
                rd_data[`CSL_BIT_IE] <= tx_irq_enable;
                rd_data[`CSL_BIT_LOOPBACK] <= loopback_test;
                rd_data[`CSL_BIT_FORCE_SPACE] <= force_space;
            end
            if (rd_en & (addr == `CSL_ADDR_BOOT_DIAG))
                rd_data[`CSL_BIT_RATE_LO+2:`CSL_BIT_RATE_LO] <= ~rate_switch_in;
        end
    end

    // ****************************************
    // interrupt requests
    // ****************************************
    // error flags never request on their own; receiver takes priority
    assign rx_irq_req = rx_irq_enable & rx_char_done;
    assign tx_irq_req = tx_irq_enable & tx_can_accept;
    assign irq_level = `CSL_IRQ_LEVEL;
    assign irq_vector = rx_irq_req ? `CSL_VECTOR_RX : `CSL_VECTOR_TX;

endmodule

`default_nettype wire

/* csl_terminal_model.sv */
// terminal model on the far side of the serial line
// assumes one system clock; line is MARK when idle
`timescale 1ns/1ps
`default_nettype none
module csl_terminal_model #(
    parameter int BIT_CYC = 1040
) (
    input wire logic clock,
    input wire logic send,
    input wire logic [7:0] data,
    input wire logic bad_stop,
    input wire logic hold_space,
    output logic line,
    output logic busy
);
    logic [9:0] frame;
    int cnt;
    int nbit;
    initial busy = 1'b0;
    // start, 8 data lsb first, stop; bad_stop sends SPACE as stop
    always @(posedge clock)
    begin
        if (send && !busy)
        begin
            frame <= {~bad_stop, data, 1'b0};
            busy <= 1'b1;
            cnt <= 0;
            nbit <= 0;
        end
        else if (busy && cnt == BIT_CYC - 1)
        begin
            cnt <= 0;
            nbit <= nbit + 1;
            busy <= (nbit != 9);
        end
        else if (busy)
            cnt <= cnt + 1;
    end
    // hold_space is the deliberate break; otherwise idle MARK
    assign line = hold_space ? 1'b0 : (busy ? frame[nbit] : 1'b1);
endmodule
`default_nettype wire

/* csl_console_uart_monitor.sv */
// port checker for the console serial line block
// assumes it is bound into csl_console_uart
`timescale 1ns/1ps
`include "csl_console_uart_defs.vh"
`default_nettype none
module csl_console_uart_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] rd_data,
    input wire logic [2:0] baud_select,
    input wire logic [2:0] rate_switch_in,
    input wire logic dc_power_ok,
    input wire logic system_ctrl_hold,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic rx_irq_req,
    input wire logic tx_irq_req,
    input wire logic [4:0] irq_level,
    input wire logic [7:0] irq_vector
);
    logic loop_on;
    logic brk_on;
    // shadows of the loopback and break bits, since the checker cannot see registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loop_on <= 1'b0;
            brk_on <= 1'b0;
        end
        else if (!dc_power_ok && !system_ctrl_hold)
        begin
            loop_on <= 1'b0;
            brk_on <= 1'b0;
        end
        else if (wr_en && addr == `CSL_ADDR_TX_CTRL_STATUS)
        begin
            loop_on <= wr_data[2];
            brk_on <= wr_data[0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_rd(a);
        rd_en && addr == a;
    endsequence
    sequence s_txload;
        wr_en && addr == `CSL_ADDR_TX_BUFFER && tx_irq_req;
    endsequence
    AST_LEVEL: assert property (irq_level == 5'h0e)
        else $error("interrupt level is not 14");
    AST_RX_VEC: assert property (rx_irq_req |-> irq_vector == 8'hf8)
        else $error("receive vector wrong");
    AST_TX_VEC: assert property (tx_irq_req && !rx_irq_req |-> irq_vector == 8'hfc)
        else $error("transmit vector wrong");
    AST_RX_CLR: assert property (s_rd(`CSL_ADDR_RX_BUFFER) ##0 rx_irq_req |=> !rx_irq_req)
        else $error("buffer read left receive request up");
    AST_TX_LOAD: assert property (s_txload |=> !tx_irq_req)
        else $error("load did not drop can-accept");
    AST_LOOP: assert property (loop_on |-> serial_out)
        else $error("line left MARK in loopback");
    // a forced space is not a start bit, so it is left out
    AST_START: assert property ($fell(serial_out) && !loop_on && !brk_on |-> !serial_out [*8])
        else $error("start bit too short");
    AST_SOFT: assert property (!dc_power_ok && !system_ctrl_hold |=> !rx_irq_req && !tx_irq_req)
        else $error("soft init left an enable set");
    AST_IDLE_RD: assert property (!rd_en |=> rd_data == 32'h0)
        else $error("read data not zero between reads");
    AST_RECEIVE_CONTROL_STATUS_UNUSED: assert property (s_rd(`CSL_ADDR_RX_CTRL_STATUS) |=>
        rd_data[31:8] == 24'h0 && rd_data[5:0] == 6'h0)
        else $error("unused status bits not zero");
    AST_ERR_SUM: assert property (s_rd(`CSL_ADDR_RX_BUFFER) |=>
        rd_data[15] == (rd_data[14] | rd_data[13]) && rd_data[31:16] == 16'h0)
        else $error("error summary bit wrong");
endmodule
bind csl_console_uart csl_console_uart_monitor csl_console_uart_monitor_i (.clock(clock),
    .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data),
    .rd_data(rd_data), .baud_select(baud_select), .rate_switch_in(rate_switch_in),
    .dc_power_ok(dc_power_ok), .system_ctrl_hold(system_ctrl_hold), .serial_in(serial_in),
    .serial_out(serial_out), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
    .irq_level(irq_level), .irq_vector(irq_vector));
`default_nettype wire

/* csl_console_uart_test.sv */
// self-checking bench for the console serial line block
// assumes the terminal model on serial_in and the bound checker
`timescale 1ns/1ps
`include "csl_console_uart_defs.vh"
`default_nettype none
module csl_console_uart_test;
    localparam int BIT_CYC = 1040; // rate code 7: 16 ticks of 65 cycles
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] addr = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] wr_data = 32'h0;
    logic [2:0] rate_switch_in = 3'h6;
    logic [2:0] baud_code = 3'h7;
    logic dc_power_ok = 1'b1;
    logic system_ctrl_hold = 1'b0;
    logic send = 1'b0;
    logic [7:0] tx_byte = 8'h0;
    logic bad_stop = 1'b0;
    logic hold_space = 1'b0;
    logic [31:0] rd_data;
    logic serial_in;
    logic serial_out;
    logic rx_irq_req;
    logic tx_irq_req;
    logic [4:0] irq_level;
    logic [7:0] irq_vector;
    logic [31:0] rd;
    int fail_count = 0;
    int comparisons = 0;

    // 40 MHz system clock
    always #12.5 clock = ~clock;

    csl_console_uart csl_console_uart_i (.clock(clock), .rst_n(rst_n), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
        .baud_select(baud_code), .rate_switch_in(rate_switch_in), .dc_power_ok(dc_power_ok),
        .system_ctrl_hold(system_ctrl_hold), .serial_in(serial_in), .serial_out(serial_out),
        .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .irq_level(irq_level),
        .irq_vector(irq_vector));
    csl_terminal_model #(.BIT_CYC(BIT_CYC)) csl_terminal_model_i (.clock(clock), .send(send),
        .data(tx_byte), .bad_stop(bad_stop), .hold_space(hold_space), .line(serial_in),
        .busy());

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // read data lands one cycle after the strobe edge
    task automatic rdreg(input logic [31:0] a);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 rd = rd_data;
    endtask
    // fixed pacing: ten bit frame plus one idle bit
    task automatic frame(input logic [7:0] b, input logic bad);
        @(posedge clock);
        tx_byte <= b;
        bad_stop <= bad;
        send <= 1'b1;
        @(posedge clock);
        send <= 1'b0;
        repeat (11 * BIT_CYC) @(posedge clock);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic t_reset();
        chk({31'h0, serial_out}, 32'h1, "idle line");
        chk({27'h0, irq_level}, 32'he, "level");
        rdreg(`CSL_ADDR_RX_CTRL_STATUS);
        chk(rd, 32'h0, "rx status reset");
        rdreg(`CSL_ADDR_TX_CTRL_STATUS);
        chk(rd, 32'h80, "tx status reset");
        rdreg(`CSL_ADDR_RX_BUFFER);
        chk(rd, 32'h0, "rx buffer reset");
        rdreg(32'h10140090);
        chk(rd, 32'h0, "unmapped");
        rdreg(`CSL_ADDR_BOOT_DIAG);
        chk(rd, 32'h10, "switch code");
        $display("t_reset done");
    endtask
    task automatic t_regs();
        wr(`CSL_ADDR_RX_CTRL_STATUS, 32'hffffffff);
        rdreg(`CSL_ADDR_RX_CTRL_STATUS);
        chk(rd, 32'h40, "rx status bits");
        wr(`CSL_ADDR_RX_BUFFER, 32'hffffffff);
        rdreg(`CSL_ADDR_RX_BUFFER);
        chk(rd, 32'h0, "rx buffer read-only");
        wr(`CSL_ADDR_TX_CTRL_STATUS, 32'hffffffff);
        rdreg(`CSL_ADDR_TX_CTRL_STATUS);
        chk(rd, 32'hc5, "tx status bits");
        chk({31'h0, tx_irq_req}, 32'h1, "tx request");
        chk({31'h0, serial_out}, 32'h1, "loopback beats break");
        wr(`CSL_ADDR_TX_CTRL_STATUS, 32'h1);
        repeat (2) @(posedge clock);
        chk({31'h0, serial_out}, 32'h0, "forced space");
        wr(`CSL_ADDR_TX_CTRL_STATUS, 32'h0);
        // the space latch lets go one cycle after the bit clears
        @(posedge clock);
        #1 chk({30'h0, serial_out, tx_irq_req}, 32'h2, "break off, tx masked");
        $display("t_regs done");
    endtask
    task automatic t_loop();
        int n;
        n = 0;
        wr(`CSL_ADDR_TX_CTRL_STATUS, 32'h44);
        wr(`CSL_ADDR_TX_BUFFER, 32'hffffffa5);
        while (rx_irq_req !== 1'b1 && n < 15 * BIT_CYC)
        begin
            @(posedge clock);
            n++;
        end
        chk({24'h0, irq_vector}, 32'hf8, "rx vector");
        rdreg(`CSL_ADDR_RX_BUFFER);
        chk(rd, 32'ha5, "looped char");
        chk({30'h0, rx_irq_req, tx_irq_req}, 32'h1, "done cleared, tx free");
        wr(`CSL_ADDR_TX_CTRL_STATUS, 32'h0);
        $display("t_loop done");
    endtask
    // pin frame at rate code 7 sampled mid-bit, then start bit length at code 6
    task automatic t_tx();
        int n;
        logic [9:0] want_bits;
        n = 0;
        want_bits = {1'b1, 8'h3c, 1'b0};
        wr(`CSL_ADDR_TX_BUFFER, 32'h3c);
        while (serial_out !== 1'b0 && n < 2 * BIT_CYC)
        begin
            @(negedge clock);
            n++;
        end
        repeat (BIT_CYC / 2) @(negedge clock);
        for (int i = 0; i < 10; i++)
        begin
            chk({31'h0, serial_out}, {31'h0, want_bits[i]}, "pin frame bit");
            repeat (BIT_CYC) @(negedge clock);
        end
        @(posedge clock);
        baud_code <= 3'h6;
        wr(`CSL_ADDR_TX_BUFFER, 32'h55);
        n = 0;
        while (serial_out !== 1'b0 && n < 4 * BIT_CYC)
        begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (serial_out === 1'b0 && n < 4 * BIT_CYC)
        begin
            @(negedge clock);
            n++;
        end
        chk(n, 2 * BIT_CYC, "start bit at rate code 6");
        @(posedge clock);
        baud_code <= 3'h7;
        repeat (10 * BIT_CYC) @(posedge clock);
        $display("t_tx done");
    endtask
    task automatic t_rx_err();
        frame(8'h3c, 1'b0);
        frame(8'hc3, 1'b1);
        rdreg(`CSL_ADDR_RX_BUFFER);
        chk(rd, 32'he0c3, "overrun and framing");
        frame(8'h5a, 1'b0);
        rdreg(`CSL_ADDR_RX_BUFFER);
        chk(rd, 32'h5a, "flags refreshed");
        $display("t_rx_err done");
    endtask
    task automatic t_break();
        @(posedge clock);
        hold_space <= 1'b1;
        repeat (22 * BIT_CYC) @(posedge clock);
        hold_space <= 1'b0;
        repeat (2 * BIT_CYC) @(posedge clock);
        rdreg(`CSL_ADDR_RX_BUFFER);
        chk(rd, 32'ha800, "break with framing");
        rdreg(`CSL_ADDR_RX_BUFFER);
        chk(rd, 32'ha000, "break cleared by read");
        $display("t_break done");
    endtask
    task automatic t_soft();
        wr(`CSL_ADDR_TX_CTRL_STATUS, 32'h44);
        system_ctrl_hold <= 1'b1;
        dc_power_ok <= 1'b0;
        repeat (2) @(posedge clock);
        chk({31'h0, tx_irq_req}, 32'h1, "hold blocks init");
        system_ctrl_hold <= 1'b0;
        repeat (2) @(posedge clock);
        dc_power_ok <= 1'b1;
        rdreg(`CSL_ADDR_TX_CTRL_STATUS);
        chk(rd, 32'h80, "soft init");
        $display("t_soft done");
    endtask

    // reset, then the scenarios in order
    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_loop();
        t_tx();
        t_rx_err();
        t_break();
        t_soft();
        end_sim();
    end
    // watchdog: scenarios need about 93000 cycles
    initial
    begin
        repeat (100000) @(posedge clock);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule
`default_nettype wire
